// File: hdl/dpx_classifier.sv
// Exception classifier for double-precision packed and scalar vector operations
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - packed add: all but divide-by-zero
// - scalar add: lowest lane, no divide-by-zero
// - and-not inverts destination, ANDs source
// - vector AND raises no conditions
// - packed compare: predicate, invalid and denormal
// - scalar compare: lowest lane, invalid, denormal
// - ordered compare writes flags; invalid, denormal
// - four ints to single: precision only
// - single to int rounded: invalid, precision
// - truncating conversions: invalid and precision only
// - rounding double to int: invalid, precision
// - int to double conversions raise nothing
// - double to single: all but divide-by-zero
// - single to double: invalid and denormal
// - divide may raise all six conditions
// - maximum and minimum: invalid and denormal
// - aligned 128-bit move raises nothing
// - upper half 64-bit move raises nothing
// - lower half 64-bit move raises nothing
// - scalar 64-bit move raises nothing
// - sign mask to general register, nothing
////////////////////////////////////////////////////////////////////////////////
module dpx_classifier #(
   parameter int LANES  = dpx_pkg::LANES,
   parameter int COND_W = dpx_pkg::COND_W,
   parameter int VEC_W  = dpx_pkg::VEC_W
) (
   input  wire logic                    sys_clk_in,
   input  wire logic                    arst_n_in,
   input  wire logic                    op_valid_in,
   input  wire logic [5:0]              op_code_in,
   input  wire logic [dpx_pkg::PRED_W-1:0] compare_predicate_immediate_in,
   input  wire logic [dpx_pkg::RC_W-1:0]   ctrl_round_mode_in,
   input  wire logic [VEC_W-1:0]        dest_vec_in,
   input  wire logic [VEC_W-1:0]        src_vec_in,
   input  wire logic                    exec_valid_in,
   input  wire logic [LANES*COND_W-1:0] lane_cond_in,
   output logic                         ready_out,
   output logic                         exec_req_out,
   output logic                         done_out,
   output logic                         illegal_out,
   output logic [COND_W-1:0]            cond_out,
   output logic [COND_W-1:0]            cap_mask_out,
   output logic [LANES-1:0]             lane_mask_out,
   output logic [dpx_pkg::RC_W-1:0]     round_mode_out,
   output logic                         round_from_ctrl_out,
   output logic [dpx_pkg::PRED_W-1:0]   predicate_out,
   output logic                         writes_status_flags_out,
   output logic                         gpr_dest_out,
   output logic [VEC_W-1:0]             result_out
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [COND_W-1:0]      cap;
      logic [LANES-1:0]       lanes;
      dpx_pkg::dpx_kind_t     kind;
      dpx_pkg::dpx_rsrc_t     rsrc;
      logic                   pred;
      logic                   flags;
      logic                   gpr;
      logic                   legal;
   } dpx_desc_t;

   typedef struct packed {
      dpx_pkg::dpx_state_t       st;
      logic                      ready;
      logic                      exec_req;
      logic                      done;
      logic                      illegal;
      logic [COND_W-1:0]         cond;
      logic [COND_W-1:0]         cap;
      logic [LANES-1:0]          lanes;
      logic [dpx_pkg::RC_W-1:0]  rmode;
      logic                      rctrl;
      logic [dpx_pkg::PRED_W-1:0] pred;
      logic                      flags;
      logic                      gpr;
   } dpx_top_t;

   dpx_top_t          r;
   dpx_top_t          next_r;
   dpx_desc_t         dec;
   logic              accept;
   logic [COND_W-1:0] lane_or;

   assign accept = op_valid_in && r.ready;

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the incoming operation
   always_comb begin
      dec       = '0;
      dec.kind  = dpx_pkg::K_NONE;
      dec.rsrc  = dpx_pkg::RS_NONE;
      dec.legal = 1'b1;
      case (op_code_in)
         dpx_pkg::OP_ADD_PACKED_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ARITH;
            dec.lanes = dpx_pkg::LM_DOUBLE;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_ADD_SCALAR_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ARITH;
            dec.lanes = dpx_pkg::LM_SCALAR;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_AND_NOT_VECTOR: begin
            dec.kind  = dpx_pkg::K_ANDN;
         end
         dpx_pkg::OP_AND_VECTOR: begin
            dec.kind  = dpx_pkg::K_AND;
         end
         dpx_pkg::OP_COMPARE_PACKED_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ID;
            dec.lanes = dpx_pkg::LM_DOUBLE;
            dec.pred  = 1'b1;
         end
         dpx_pkg::OP_COMPARE_SCALAR_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ID;
            dec.lanes = dpx_pkg::LM_SCALAR;
            dec.pred  = 1'b1;
         end
         dpx_pkg::OP_ORDERED_COMPARE_TO_FLAGS: begin
            dec.cap   = dpx_pkg::CAP_ID;
            dec.lanes = dpx_pkg::LM_SCALAR;
            dec.flags = 1'b1;
         end
         dpx_pkg::OP_INT_TO_SINGLE_PACKED: begin
            dec.cap   = dpx_pkg::CAP_P;
            dec.lanes = dpx_pkg::LM_QUAD;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_SINGLE_TO_INT_ROUNDED: begin
            dec.cap   = dpx_pkg::CAP_IP;
            dec.lanes = dpx_pkg::LM_QUAD;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_SINGLE_TO_INT_TRUNCATED: begin
            dec.cap   = dpx_pkg::CAP_IP;
            dec.lanes = dpx_pkg::LM_QUAD;
            dec.rsrc  = dpx_pkg::RS_TRUNC;
         end
         dpx_pkg::OP_DOUBLE_TO_INT_TRUNCATED,
         dpx_pkg::OP_DOUBLE_TO_LEGACY_INT_TRUNC: begin
            dec.cap   = dpx_pkg::CAP_IP;
            dec.lanes = dpx_pkg::LM_DOUBLE;
            dec.rsrc  = dpx_pkg::RS_TRUNC;
         end
         dpx_pkg::OP_SCALAR_DOUBLE_TO_GPR_TRN: begin
            dec.cap   = dpx_pkg::CAP_IP;
            dec.lanes = dpx_pkg::LM_SCALAR;
            dec.rsrc  = dpx_pkg::RS_TRUNC;
            dec.gpr   = 1'b1;
         end
         dpx_pkg::OP_DOUBLE_TO_INT_ROUNDED,
         dpx_pkg::OP_DOUBLE_TO_LEGACY_INT_RND: begin
            dec.cap   = dpx_pkg::CAP_IP;
            dec.lanes = dpx_pkg::LM_DOUBLE;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_SCALAR_DOUBLE_TO_GPR_RND: begin
            dec.cap   = dpx_pkg::CAP_IP;
            dec.lanes = dpx_pkg::LM_SCALAR;
            dec.rsrc  = dpx_pkg::RS_CTRL;
            dec.gpr   = 1'b1;
         end
         dpx_pkg::OP_INT_TO_DOUBLE_PACKED,
         dpx_pkg::OP_LEGACY_INT_TO_DOUBLE,
         dpx_pkg::OP_GPR_INT_TO_SCALAR_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_NONE;
         end
         dpx_pkg::OP_DOUBLE_TO_SINGLE_PACKED: begin
            dec.cap   = dpx_pkg::CAP_ARITH;
            dec.lanes = dpx_pkg::LM_DOUBLE;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_SCALAR_DOUBLE_TO_SINGLE: begin
            dec.cap   = dpx_pkg::CAP_ARITH;
            dec.lanes = dpx_pkg::LM_SCALAR;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_SINGLE_TO_DOUBLE_PACKED: begin
            dec.cap   = dpx_pkg::CAP_ID;
            dec.lanes = dpx_pkg::LM_DOUBLE;
         end
         dpx_pkg::OP_SCALAR_SINGLE_TO_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ID;
            dec.lanes = dpx_pkg::LM_SCALAR;
         end
         dpx_pkg::OP_DIVIDE_PACKED_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ALL;
            dec.lanes = dpx_pkg::LM_DOUBLE;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_DIVIDE_SCALAR_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ALL;
            dec.lanes = dpx_pkg::LM_SCALAR;
            dec.rsrc  = dpx_pkg::RS_CTRL;
         end
         dpx_pkg::OP_MAXIMUM_PACKED_DOUBLE,
         dpx_pkg::OP_MINIMUM_PACKED_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ID;
            dec.lanes = dpx_pkg::LM_DOUBLE;
         end
         dpx_pkg::OP_MAXIMUM_SCALAR_DOUBLE,
         dpx_pkg::OP_MINIMUM_SCALAR_DOUBLE: begin
            dec.cap   = dpx_pkg::CAP_ID;
            dec.lanes = dpx_pkg::LM_SCALAR;
         end
         dpx_pkg::OP_ALIGNED_VECTOR_MOVE: begin
            dec.kind  = dpx_pkg::K_FULL;
         end
         dpx_pkg::OP_UPPER_HALF_MOVE_LOAD: begin
            dec.kind  = dpx_pkg::K_LOAD_HI;
         end
         dpx_pkg::OP_UPPER_HALF_MOVE_STORE: begin
            dec.kind  = dpx_pkg::K_STORE_HI;
         end
         dpx_pkg::OP_LOWER_HALF_MOVE_LOAD: begin
            dec.kind  = dpx_pkg::K_LOAD_LO;
         end
         dpx_pkg::OP_LOWER_HALF_MOVE_STORE: begin
            dec.kind  = dpx_pkg::K_STORE_LO;
         end
         dpx_pkg::OP_SIGN_MASK_EXTRACT: begin
            dec.kind  = dpx_pkg::K_MASK;
            dec.gpr   = 1'b1;
         end
         dpx_pkg::OP_SCALAR_DOUBLE_MOVE: begin
            dec.kind  = dpx_pkg::K_SCALAR;
         end
         default: begin
            dec.legal = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // lanes merged per instruction
   dpx_lane_or #(
      .LANES  (LANES),
      .COND_W (COND_W)
   ) u_lane_or (
      .lane_cond_in (lane_cond_in),
      .lane_mask_in (r.lanes),
      .cap_in       (r.cap),
      .cond_out     (lane_or)
   );

   // data results for logic and moves
   dpx_vec_datapath #(
      .VEC_W  (VEC_W),
      .HALF_W (dpx_pkg::HALF_W)
   ) u_datapath (
      .sys_clk_in (sys_clk_in),
      .arst_n_in  (arst_n_in),
      .load_in    (accept),
      .kind_in    (dec.kind),
      .dest_in    (dest_vec_in),
      .src_in     (src_vec_in),
      .result_out (result_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing
   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      case (r.st)
         dpx_pkg::ST_IDLE: begin
            if (accept) begin
               next_r.cap     = dec.cap;
               next_r.lanes   = dec.lanes;
               next_r.illegal = !dec.legal;
               next_r.flags   = dec.flags;
               next_r.gpr     = dec.gpr;
               next_r.rctrl   = (dec.rsrc == dpx_pkg::RS_CTRL);
               next_r.pred    = dec.pred ? compare_predicate_immediate_in : '0;
               if (dec.rsrc == dpx_pkg::RS_CTRL) begin
                  next_r.rmode = ctrl_round_mode_in;
               end else if (dec.rsrc == dpx_pkg::RS_TRUNC) begin
                  next_r.rmode = dpx_pkg::RC_TRUNC;
               end else begin
                  next_r.rmode = dpx_pkg::RC_NEAREST;
               end
               // Silent operations report at once, no pipeline round trip
               if (dec.lanes == dpx_pkg::LM_NONE) begin
                  next_r.done = 1'b1;
                  next_r.cond = '0;
               end else begin
                  next_r.st       = dpx_pkg::ST_WAIT;
                  next_r.ready    = 1'b0;
                  next_r.exec_req = 1'b1;
               end
            end
         end
         dpx_pkg::ST_WAIT: begin
            if (exec_valid_in) begin
               next_r.cond     = lane_or;
               next_r.done     = 1'b1;
               next_r.st       = dpx_pkg::ST_IDLE;
               next_r.ready    = 1'b1;
               next_r.exec_req = 1'b0;
            end
         end
         default: begin
            next_r.st       = dpx_pkg::ST_IDLE;
            next_r.ready    = 1'b1;
            next_r.exec_req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r       <= '0;
         r.st    <= dpx_pkg::ST_IDLE;
         r.ready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign ready_out               = r.ready;
   assign exec_req_out            = r.exec_req;
   assign done_out                = r.done;
   assign illegal_out             = r.illegal;
   assign cond_out                = r.cond;
   assign cap_mask_out            = r.cap;
   assign lane_mask_out           = r.lanes;
   assign round_mode_out          = r.rmode;
   assign round_from_ctrl_out     = r.rctrl;
   assign predicate_out           = r.pred;
   assign writes_status_flags_out = r.flags;
   assign gpr_dest_out            = r.gpr;
endmodule

// File: hdl/dpx_pkg.sv
// Shared constants and types for the double-precision exception classifier
package dpx_pkg;
   localparam int COND_W = 6;
   localparam int LANES  = 4;
   localparam int VEC_W  = 128;
   localparam int HALF_W = 64;
   localparam int MASK_W = 32;
   localparam int PRED_W = 8;
   localparam int RC_W   = 2;
   localparam int LM_W   = 4;
   // Condition bit positions
   localparam int C_INV  = 0;
   localparam int C_DEN  = 1;
   localparam int C_DIVZ = 2;
   localparam int C_OVF  = 3;
   localparam int C_UNF  = 4;
   localparam int C_PRE  = 5;
   // Capability masks
   localparam logic [COND_W-1:0] CAP_NONE  = 6'h00;
   localparam logic [COND_W-1:0] CAP_ID    = 6'h03;
   localparam logic [COND_W-1:0] CAP_P     = 6'h20;
   localparam logic [COND_W-1:0] CAP_IP    = 6'h21;
   localparam logic [COND_W-1:0] CAP_ARITH = 6'h3B;
   localparam logic [COND_W-1:0] CAP_ALL   = 6'h3F;
   // Active lane masks
   localparam logic [LM_W-1:0] LM_NONE   = 4'h0;
   localparam logic [LM_W-1:0] LM_SCALAR = 4'h1;
   localparam logic [LM_W-1:0] LM_DOUBLE = 4'h3;
   localparam logic [LM_W-1:0] LM_QUAD   = 4'hF;
   // Rounding codes
   localparam logic [RC_W-1:0] RC_NEAREST = 2'h0;
   localparam logic [RC_W-1:0] RC_TRUNC   = 2'h3;
   // Sign bit positions of the two double elements
   localparam int SIGN_LO = 63;
   localparam int SIGN_HI = 127;

   typedef enum logic [5:0] {
      OP_ADD_PACKED_DOUBLE        = 6'h00, OP_ADD_SCALAR_DOUBLE          = 6'h01,
      OP_AND_NOT_VECTOR           = 6'h02, OP_AND_VECTOR                 = 6'h03,
      OP_COMPARE_PACKED_DOUBLE    = 6'h04, OP_COMPARE_SCALAR_DOUBLE      = 6'h05,
      OP_ORDERED_COMPARE_TO_FLAGS = 6'h06, OP_INT_TO_SINGLE_PACKED       = 6'h07,
      OP_SINGLE_TO_INT_ROUNDED    = 6'h08, OP_SINGLE_TO_INT_TRUNCATED    = 6'h09,
      OP_INT_TO_DOUBLE_PACKED     = 6'h0A, OP_DOUBLE_TO_INT_ROUNDED      = 6'h0B,
      OP_DOUBLE_TO_LEGACY_INT_RND = 6'h0C, OP_DOUBLE_TO_SINGLE_PACKED    = 6'h0D,
      OP_LEGACY_INT_TO_DOUBLE     = 6'h0E, OP_SINGLE_TO_DOUBLE_PACKED    = 6'h0F,
      OP_SCALAR_DOUBLE_TO_GPR_RND = 6'h10, OP_SCALAR_DOUBLE_TO_SINGLE    = 6'h11,
      OP_GPR_INT_TO_SCALAR_DOUBLE = 6'h12, OP_SCALAR_SINGLE_TO_DOUBLE    = 6'h13,
      OP_DOUBLE_TO_INT_TRUNCATED  = 6'h14, OP_DOUBLE_TO_LEGACY_INT_TRUNC = 6'h15,
      OP_SCALAR_DOUBLE_TO_GPR_TRN = 6'h16, OP_DIVIDE_PACKED_DOUBLE       = 6'h17,
      OP_DIVIDE_SCALAR_DOUBLE     = 6'h18, OP_MAXIMUM_PACKED_DOUBLE      = 6'h19,
      OP_MAXIMUM_SCALAR_DOUBLE    = 6'h1A, OP_MINIMUM_PACKED_DOUBLE      = 6'h1B,
      OP_MINIMUM_SCALAR_DOUBLE    = 6'h1C, OP_ALIGNED_VECTOR_MOVE        = 6'h1D,
      OP_UPPER_HALF_MOVE_LOAD     = 6'h1E, OP_UPPER_HALF_MOVE_STORE      = 6'h1F,
      OP_LOWER_HALF_MOVE_LOAD     = 6'h20, OP_LOWER_HALF_MOVE_STORE      = 6'h21,
      OP_SIGN_MASK_EXTRACT        = 6'h22, OP_SCALAR_DOUBLE_MOVE         = 6'h23
   } dpx_op_t;

   typedef enum logic [3:0] {
      K_NONE = 4'h0, K_ANDN = 4'h1, K_AND = 4'h2, K_FULL = 4'h3,
      K_LOAD_HI = 4'h4, K_STORE_HI = 4'h5, K_LOAD_LO = 4'h6,
      K_STORE_LO = 4'h7, K_SCALAR = 4'h8, K_MASK = 4'h9
   } dpx_kind_t;

   typedef enum logic [1:0] {
      RS_NONE = 2'h0, RS_CTRL = 2'h1, RS_TRUNC = 2'h2
   } dpx_rsrc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1, ST_WAIT = 2'h2
   } dpx_state_t;
endpackage

// File: hdl/dpx_lane_or.sv
// Gates per-lane raw conditions by capability and ORs them together
module dpx_lane_or #(
   parameter int LANES  = dpx_pkg::LANES,
   parameter int COND_W = dpx_pkg::COND_W
) (
   input  wire logic [LANES*COND_W-1:0] lane_cond_in,
   input  wire logic [LANES-1:0]        lane_mask_in,
   input  wire logic [COND_W-1:0]       cap_in,
   output logic      [COND_W-1:0]       cond_out
);
   logic [COND_W-1:0] acc [LANES+1];

   assign acc[0] = '0;
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      // Idle lanes may carry stale flags from the pipeline
      assign acc[i+1] = acc[i] |
         (lane_cond_in[i*COND_W +: COND_W] & cap_in & {COND_W{lane_mask_in[i]}});
   end
   assign cond_out = acc[LANES];
endmodule

// File: hdl/dpx_vec_datapath.sv
// Registered logic, move and sign-mask datapath
module dpx_vec_datapath #(
   parameter int VEC_W  = dpx_pkg::VEC_W,
   parameter int HALF_W = dpx_pkg::HALF_W
) (
   input  wire logic              sys_clk_in,
   input  wire logic              arst_n_in,
   input  wire logic              load_in,
   input  dpx_pkg::dpx_kind_t     kind_in,
   input  wire logic [VEC_W-1:0]  dest_in,
   input  wire logic [VEC_W-1:0]  src_in,
   output logic      [VEC_W-1:0]  result_out
);
   typedef struct packed {
      logic [VEC_W-1:0] result;
   } dpx_dp_t;

   dpx_dp_t r;
   dpx_dp_t next_r;

   always_comb begin
      next_r = r;
      if (load_in) begin
         case (kind_in)
            dpx_pkg::K_ANDN:     next_r.result = ~dest_in & src_in;
            dpx_pkg::K_AND:      next_r.result = dest_in & src_in;
            dpx_pkg::K_FULL:     next_r.result = src_in;
            dpx_pkg::K_LOAD_HI:  next_r.result = {src_in[HALF_W-1:0], dest_in[HALF_W-1:0]};
            dpx_pkg::K_STORE_HI: next_r.result = {{HALF_W{1'b0}}, dest_in[VEC_W-1:HALF_W]};
            dpx_pkg::K_LOAD_LO:  next_r.result = {dest_in[VEC_W-1:HALF_W], src_in[HALF_W-1:0]};
            dpx_pkg::K_STORE_LO: next_r.result = {{HALF_W{1'b0}}, dest_in[HALF_W-1:0]};
            dpx_pkg::K_SCALAR:   next_r.result = {dest_in[VEC_W-1:HALF_W], src_in[HALF_W-1:0]};
            dpx_pkg::K_MASK:     next_r.result = {{(VEC_W-2){1'b0}},
                                                  src_in[dpx_pkg::SIGN_HI],
                                                  src_in[dpx_pkg::SIGN_LO]};
            default:             next_r.result = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign result_out = r.result;
endmodule

// File: test/dpx_classifier_chk.sv
// Port-level assertions for the exception classifier
module dpx_chk (
   input wire logic         sys_clk_in,
   input wire logic         arst_n_in,
   input wire logic         op_valid_in,
   input wire logic [5:0]   op_code_in,
   input wire logic [7:0]   compare_predicate_immediate_in,
   input wire logic [127:0] dest_vec_in,
   input wire logic [127:0] src_vec_in,
   input wire logic         exec_valid_in,
   input wire logic         ready_out,
   input wire logic         exec_req_out,
   input wire logic         done_out,
   input wire logic [5:0]   cond_out,
   input wire logic [5:0]   cap_mask_out,
   input wire logic [3:0]   lane_mask_out,
   input wire logic [7:0]   predicate_out,
   input wire logic         writes_status_flags_out,
   input wire logic [127:0] result_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acc;
   assign acc = op_valid_in && ready_out;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   silent_done_a: assert property (acc |=> done_out == (lane_mask_out == 4'h0))
      else $error("done timing wrong after accept");
   wait_busy_a: assert property (exec_req_out |-> !ready_out && !done_out)
      else $error("ready or done while waiting");
   answer_done_a: assert property (exec_req_out && exec_valid_in |=> done_out && ready_out)
      else $error("answer not reported next cycle");
   cap_only_a: assert property (done_out |-> (cond_out & ~cap_mask_out) == 6'h00)
      else $error("condition outside capability");
   silent_cond_a: assert property (done_out && lane_mask_out == 4'h0 |-> cond_out == 6'h00)
      else $error("silent op raised a condition");
   and_not_a: assert property (acc && op_code_in == 6'h02 |=>
      result_out == (~$past(dest_vec_in) & $past(src_vec_in))) else $error("and-not result");
   and_vec_a: assert property (acc && op_code_in == 6'h03 |=>
      result_out == ($past(dest_vec_in) & $past(src_vec_in))) else $error("and result");
   div_caps_a: assert property (acc && op_code_in == 6'h17 |=>
      cap_mask_out == 6'h3F && lane_mask_out == 4'h3) else $error("divide descriptor");
   add_caps_a: assert property (acc && op_code_in == 6'h00 |=> cap_mask_out == 6'h3B)
      else $error("add capability");
   cmp_pred_a: assert property (acc && op_code_in == 6'h04 |=>
      predicate_out == $past(compare_predicate_immediate_in)) else $error("predicate lost");
   flag_lane_a: assert property (acc && op_code_in == 6'h06 |=>
      writes_status_flags_out && lane_mask_out == 4'h1) else $error("ordered compare");
   cover property (acc && op_code_in == 6'h17);
   cover property (done_out ##1 done_out);
   cover property (exec_req_out && exec_valid_in);
endmodule
bind dpx_classifier dpx_chk u_chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
   .op_valid_in(op_valid_in), .op_code_in(op_code_in), .dest_vec_in(dest_vec_in),
   .compare_predicate_immediate_in(compare_predicate_immediate_in), .src_vec_in(src_vec_in),
   .exec_valid_in(exec_valid_in), .ready_out(ready_out), .exec_req_out(exec_req_out),
   .done_out(done_out), .cond_out(cond_out), .cap_mask_out(cap_mask_out),
   .lane_mask_out(lane_mask_out), .predicate_out(predicate_out), .result_out(result_out),
   .writes_status_flags_out(writes_status_flags_out));

// File: test/dpx_pipe_model.sv
// Execution pipeline model answering after a random wait
module dpx_pipe_model (
   input  wire logic        sys_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        exec_req_in,
   output logic             exec_valid_out = 1'b0,
   output logic [23:0]      lane_cond_out = 24'h000000
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt = 2'h0;
   // Lanes churn every cycle, so a dropped lane never matches by luck
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         exec_valid_out <= 1'b0;
         wait_cnt <= 2'h0;
      end else begin
         lane_cond_out <= 24'($urandom);
         if (exec_valid_out || !exec_req_in) begin
            exec_valid_out <= 1'b0;
            wait_cnt <= 2'($urandom);
         end else if (wait_cnt == 2'h0) begin
            exec_valid_out <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt - 2'h1;
         end
      end
   end
endmodule

// File: test/dpx_classifier_tb.sv
// Self-checking bench for the exception classifier
module dpx_classifier_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [5:0] op; logic [127:0] d; logic [127:0] s; logic [7:0] imm;
      logic [1:0] rm;} dpx_req_t;
   logic         sys_clk_in = 1'b0, arst_n_in = 1'b0, op_valid_in = 1'b0;
   logic [5:0]   op_code_in = 6'h00, cond, cap;
   logic [7:0]   imm = 8'h00, pred;
   logic [1:0]   rm = 2'h0, rmo;
   logic [127:0] dest = 128'h0, src = 128'h0, result;
   logic [23:0]  lane_cond, lc = 24'h000000;
   logic [3:0]   lanes;
   logic         exec_valid, ready, exec_req, done, illegal, rfc, wsf, gpr;
   int           miscompares = 0, n_checks = 0;
   dpx_req_t     q[$];
   always #5 sys_clk_in = ~sys_clk_in;
   dpx_classifier dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .op_valid_in(op_valid_in),
      .op_code_in(op_code_in), .compare_predicate_immediate_in(imm), .ctrl_round_mode_in(rm),
      .dest_vec_in(dest), .src_vec_in(src), .exec_valid_in(exec_valid), .lane_cond_in(lane_cond),
      .ready_out(ready), .exec_req_out(exec_req), .done_out(done), .illegal_out(illegal),
      .cond_out(cond), .cap_mask_out(cap), .lane_mask_out(lanes), .round_mode_out(rmo),
      .round_from_ctrl_out(rfc), .predicate_out(pred), .writes_status_flags_out(wsf),
      .gpr_dest_out(gpr), .result_out(result));
   dpx_pipe_model u_pipe (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .exec_req_in(exec_req), .exec_valid_out(exec_valid), .lane_cond_out(lane_cond));
   ////////////////////////////////////////////////////////////////////////////////
   // Lane mask and capability per operation
   function automatic logic [9:0] info(input logic [5:0] op);
      case (op)
         6'h00, 6'h0D: return {4'h3, 6'h3B};
         6'h01, 6'h11: return {4'h1, 6'h3B};
         6'h04, 6'h0F, 6'h19, 6'h1B: return {4'h3, 6'h03};
         6'h05, 6'h06, 6'h13, 6'h1A, 6'h1C: return {4'h1, 6'h03};
         6'h07: return {4'hF, 6'h20};
         6'h08, 6'h09: return {4'hF, 6'h21};
         6'h0B, 6'h0C, 6'h14, 6'h15: return {4'h3, 6'h21};
         6'h10, 6'h16: return {4'h1, 6'h21};
         6'h17: return {4'h3, 6'h3F};
         6'h18: return {4'h1, 6'h3F};
         default: return 10'h000;
      endcase
   endfunction
   function automatic logic [127:0] res(input dpx_req_t r);
      case (r.op)
         6'h02: return ~r.d & r.s;
         6'h03: return r.d & r.s;
         6'h1D: return r.s;
         6'h1E: return {r.s[63:0], r.d[63:0]};
         6'h1F: return {64'h0, r.d[127:64]};
         6'h20, 6'h23: return {r.d[127:64], r.s[63:0]};
         6'h21: return {64'h0, r.d[63:0]};
         6'h22: return {126'h0, r.s[127], r.s[63]};
         default: return 128'h0;
      endcase
   endfunction
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [5:0] op);
      dpx_req_t r;
      r = '{op, {$urandom, $urandom, $urandom, $urandom}, {$urandom, $urandom, $urandom,
         $urandom}, 8'($urandom), 2'($urandom)};
      op_valid_in <= 1'b1;
      op_code_in <= op;
      dest <= r.d;
      src <= r.s;
      imm <= r.imm;
      rm <= r.rm;
      do @(posedge sys_clk_in); while (ready !== 1'b1);
      q.push_back(r);
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk_in) begin
      dpx_req_t r;
      logic [9:0] inf;
      logic [5:0] ec;
      if (exec_req === 1'b1 && exec_valid === 1'b1) lc = lane_cond;
      // A report with nothing outstanding is a spurious done
      if (done === 1'b1 && q.size() == 0) chk(128'h1, 128'h0);
      if (done === 1'b1 && q.size() > 0) begin
         r = q.pop_front();
         inf = info(r.op);
         ec = 6'h00;
         for (int i = 0; i < 4; i++) if (inf[6+i]) ec |= lc[6*i +: 6] & inf[5:0];
         chk(128'(cond), 128'(ec));
         chk(128'({lanes, cap}), 128'(inf));
         chk(result, res(r));
         chk(128'({illegal, wsf, gpr}), 128'({r.op > 6'h23, r.op == 6'h06,
            r.op inside {6'h10, 6'h16, 6'h22}}));
         chk(128'(pred), 128'(r.op inside {6'h04, 6'h05} ? r.imm : 8'h00));
         if (r.op inside {6'h08, 6'h0B, 6'h0C, 6'h10})
            chk(128'({rfc, rmo}), 128'({1'b1, r.rm}));
         if (r.op inside {6'h09, 6'h14, 6'h15, 6'h16})
            chk(128'({rfc, rmo}), 128'({1'b0, 2'h3}));
      end
   end
   // Generous bound: about fifteen thousand cycles against some six hundred needed at most
   initial begin
      #150000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'hEB71));
      repeat (6) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      @(posedge sys_clk_in);
      for (int i = 0; i < 37; i++) send(6'(i));
      repeat (60) send(6'($urandom_range(0, 36)));
      op_valid_in <= 1'b0;
      repeat (12) @(posedge sys_clk_in);
      chk(128'(q.size()), 128'h0);
      report_and_stop();
   end
endmodule
